// file: crs_pkg.sv
// Package for the clock and reset sequencer: timing constants, encodings, carriers.
// Assumes a single 100 MHz reference clock; analogue detectors arrive as plain levels.
package crs_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SLOW_RC_SETTLE_US = 100;
   localparam int SLOW_RC_SETTLE_CYC = SLOW_RC_SETTLE_US * CLK_MHZ;
   localparam int XTAL_SETTLE_NS = 750000;
   localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_NS * CLK_MHZ / 1000;
   localparam int SW_PULSE_US = 1;
   localparam int SW_PULSE_CYC = SW_PULSE_US * CLK_MHZ;
   localparam int RELEASE_US = 100;
   localparam int RELEASE_CYC = RELEASE_US * CLK_MHZ;
   localparam int CNT_W = 24;
   localparam int CAL_W = 16;
   localparam logic [CAL_W-1:0] CAL_RESET = 16'h8000;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST_CTRL = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_BOD_CTRL = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_CAL = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CAL_HI = 4'hB;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

   // CLK_CTRL fields
   localparam int CC_CPU_DIV_LSB = 0;
   localparam int CC_SLOW_SEL_LSB = 2;
   localparam int CC_FAST_WAKE = 4;
   localparam int CC_AUTO_SWITCH = 5;
   localparam int CC_SW_SWITCH = 6;
   // RST_CTRL fields (write-one actions / levels)
   localparam int RC_SW_RESET = 0;
   localparam int RC_PIN_ON_SW = 1;
   localparam int RC_EXT_HOLD = 2;
   // BOD_CTRL fields
   localparam int BC_LEVEL_LSB = 0;
   localparam int BC_RST_EN = 2;
   localparam int BC_IRQ_EN = 3;
   // STATUS fields
   localparam int ST_WDOG = 0;
   localparam int ST_FAST_SRC = 1;
   localparam int ST_RADIO_OK = 2;
   localparam int ST_BOD_LOW = 3;
   localparam int ST_BOD_IRQ = 4;

   typedef enum logic [1:0] {
      CRS_CPU_4M = 2'h0,
      CRS_CPU_8M = 2'h1,
      CRS_CPU_16M = 2'h2,
      CRS_CPU_32M = 2'h3
   } crs_cpu_div_t;

   typedef enum logic [1:0] {
      CRS_SLOW_RC = 2'h0,
      CRS_SLOW_XTAL = 2'h1,
      CRS_SLOW_EXT = 2'h2
   } crs_slow_sel_t;

   typedef enum logic [1:0] {
      CRS_BOD_2V0 = 2'h0,
      CRS_BOD_2V3 = 2'h1,
      CRS_BOD_2V7 = 2'h2,
      CRS_BOD_3V0 = 2'h3
   } crs_bod_lvl_t;

   // Gray along power-up path
   typedef enum logic [2:0] {
      CRS_ST_OFF = 3'h0,
      CRS_ST_SLOW_SETTLE = 3'h1,
      CRS_ST_XTAL_SETTLE = 3'h3,
      CRS_ST_RUN = 3'h2,
      CRS_ST_PIN_HOLD = 3'h6,
      CRS_ST_SW_PULSE = 3'h7
   } crs_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } crs_bus_t;

   typedef struct packed {
      logic por_ok;
      logic bod_above;
      logic wdog_expired;
      logic xtal_ready;
      logic wake_from_sleep;
   } crs_sense_t;
endpackage : crs_pkg

// file: crs_sequencer.sv
// Clock source selection and reset sequencing, single clock domain.
// Assumes ref_clk_i runs from power-up; analogue and pin levels are asynchronous.
`timescale 1ns/1ps
// Overview of operation
// - Derive 16 MHz main clock from 32 MHz oscillator; CPU gets selectable scaled clock.
// - Fast RC source may drive system clock, giving about 12 MHz.
// - Radio unusable while system clock comes from fast RC source.
// - Wake on fast RC, switch to crystal automatically or by software, or crystal only.
// - Slow clock selectable among internal RC, crystal or external input.
// - Slow clock selection defaults to internal RC after any chip reset.
// - Chosen crystal or external slow source stays in use until next chip reset.
// - Slow clock times sleep and runs internal logic during reset.
// - Software calibration factor may trim slow RC for sleep timing.
// - At power-up wait 100 us slow RC settle, then enable crystal.
// - Hold logic in reset until crystal stable, 0.75 ms, then release.
// - Five reset requests: power-on, pin, software, watchdog, brown-out.
// - On power-on release the pin, keep internal reset until stabilised.
// - Supply below falling power-on threshold asserts chip reset again.
// - Low pin holds reset; sequence restarts on its rising edge.
// - Reset line open-drain with pull-up; nobody drives it high.
// - Software reset is full chip reset, driving pin low for 1 us.
// - Software can pull reset line low without resetting itself.
// - Line must return high within 100 us after release, else system reset.
// - Brown-out may trigger chip reset or interrupt on either crossing.
// - Brown-out enabled at power-up, holds reset until supply is above threshold.
// - Brown-out threshold selectable four ways; fuse value at power-up, 2.3 V default.
// - Watchdog-caused reset sets a status flag for software.
module crs_sequencer (
   input wire logic ref_clk_i, // 100 MHz reference
   input wire logic rst_n_i, // Async reset, active low
   input wire crs_pkg::crs_bus_t bus_i, // Register port request
   output logic [7:0] rdata_o, // Read data, cycle after read strobe
   input wire crs_pkg::crs_sense_t sense_i, // Analogue and watchdog levels
   input wire logic [1:0] fuse_bod_lvl_i, // Brown-out level from fuses
   input wire logic chip_reset_pin_n_i, // Reset pin level
   output logic chip_reset_pin_n_o, // Reset pin drive value, always low
   output logic chip_reset_pin_n_oe_o, // Reset pin pull-down enable
   output logic core_reset_n_o, // Processor and peripheral reset
   output logic xtal_en_o, // 32 MHz crystal enable
   output logic fast_src_o, // System clock from fast RC
   output logic [1:0] cpu_div_o, // Processor clock scale
   output logic radio_en_o, // Radio usable
   output logic [1:0] slow_sel_o, // Slow clock source
   output logic [1:0] bod_lvl_o, // Brown-out threshold select
   output logic [crs_pkg::CAL_W-1:0] slow_cal_o, // Slow RC calibration factor
   output logic bod_irq_o // Brown-out crossing interrupt level
);
   import crs_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic pin_meta, pin_sync;
   logic [4:0] sense_meta, sense_sync;
   crs_sense_t sn;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= chip_reset_pin_n_i;
         pin_sync <= pin_meta;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_meta <= 5'h00;
         sense_sync <= 5'h00;
      end else begin
         sense_meta <= sense_i;
         sense_sync <= sense_meta;
      end
   end

   assign sn = crs_sense_t'(sense_sync);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   crs_state_t state;
   logic [CNT_W-1:0] cnt;
   logic pin_drive;
   logic rel_wait;
   logic [CNT_W-1:0] rel_cnt;
   logic chip_rst_req;
   logic sw_rst_req;
   logic ext_hold;
   logic bod_rst_en;
   logic wdog_flag;

   // Power-on, watchdog and brown-out (in RUN) requests that restart the whole chip
   assign chip_rst_req = !sn.por_ok
      || sn.wdog_expired
      || (bod_rst_en && !sn.bod_above && state == CRS_ST_RUN);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= CRS_ST_OFF;
         cnt <= '0;
      end else if (chip_rst_req) begin
         state <= CRS_ST_OFF;
         cnt <= '0;
      end else begin
         case (state)
            CRS_ST_OFF: begin
               cnt <= '0;
               if (sn.por_ok) begin
                  state <= CRS_ST_SLOW_SETTLE;
               end
            end
            CRS_ST_SLOW_SETTLE: begin
               cnt <= cnt + 1'b1;
               if (cnt >= CNT_W'(SLOW_RC_SETTLE_CYC - 1)) begin
                  cnt <= '0;
                  state <= CRS_ST_XTAL_SETTLE;
               end
            end
            CRS_ST_XTAL_SETTLE: begin
               if (cnt < CNT_W'(XTAL_SETTLE_CYC)) begin
                  cnt <= cnt + 1'b1;
               end
               // Brown-out stays armed through power-up
               if (cnt >= CNT_W'(XTAL_SETTLE_CYC - 1) && sn.bod_above
                   && pin_sync) begin
                  state <= CRS_ST_RUN;
               end
            end
            CRS_ST_RUN: begin
               cnt <= '0;
               if (sw_rst_req) begin
                  state <= CRS_ST_SW_PULSE;
               end else if (!pin_sync && !pin_drive && !chip_reset_pin_n_oe_o && !rel_wait) begin
                  state <= CRS_ST_PIN_HOLD;
               end else if (rel_wait && !pin_sync
                            && rel_cnt >= CNT_W'(RELEASE_CYC - 1)) begin
                  state <= CRS_ST_PIN_HOLD;
               end
            end
            CRS_ST_PIN_HOLD: begin
               cnt <= '0;
               // Rising edge of pin restarts the internal sequence
               if (pin_sync) begin
                  state <= CRS_ST_XTAL_SETTLE;
               end
            end
            CRS_ST_SW_PULSE: begin
               cnt <= cnt + 1'b1;
               if (cnt >= CNT_W'(SW_PULSE_CYC - 1)) begin
                  cnt <= '0;
                  state <= CRS_ST_XTAL_SETTLE;
               end
            end
            default: begin
               state <= CRS_ST_OFF;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reset pin and release watchdog on the line
   // ----------------------------------------------------------------
   logic soft_pull;
   // Pin drives low during power-on and software reset or by request
   assign pin_drive = (state == CRS_ST_OFF) || (state == CRS_ST_SW_PULSE && soft_pull)
      || ext_hold;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chip_reset_pin_n_oe_o <= 1'b1;
         chip_reset_pin_n_o <= 1'b0;
      end else begin
         chip_reset_pin_n_oe_o <= pin_drive;
         chip_reset_pin_n_o <= 1'b0;
      end
   end

   // Counts how long the line stays low after we stop pulling it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rel_wait <= 1'b0;
         rel_cnt <= '0;
      end else if (chip_reset_pin_n_oe_o && !pin_drive) begin
         rel_wait <= 1'b1;
         rel_cnt <= '0;
      end else if (rel_wait) begin
         rel_cnt <= rel_cnt + 1'b1;
         if (pin_sync || state != CRS_ST_RUN) begin
            rel_wait <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_reset_n_o <= 1'b0;
      end else begin
         core_reset_n_o <= (state == CRS_ST_RUN) && !chip_rst_req;
      end
   end

   // ----------------------------------------------------------------
   // Clock source control
   // ----------------------------------------------------------------
   logic [1:0] cpu_div;
   logic fast_wake, auto_switch, fast_src;
   logic [1:0] slow_sel;
   logic slow_locked;
   logic [CAL_W-1:0] cal_lo_hold;
   logic wr_clk, wr_rst, wr_bod, wr_cal;

   assign wr_clk = bus_i.wr && bus_i.addr == ADDR_CLK_CTRL;
   assign wr_rst = bus_i.wr && bus_i.addr == ADDR_RST_CTRL;
   assign wr_bod = bus_i.wr && bus_i.addr == ADDR_BOD_CTRL;
   assign wr_cal = bus_i.wr && bus_i.addr == ADDR_CAL;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_div <= CRS_CPU_16M;
         fast_wake <= 1'b0;
         auto_switch <= 1'b1;
      end else if (!core_reset_n_o) begin
         cpu_div <= CRS_CPU_16M;
      end else if (wr_clk) begin
         cpu_div <= bus_i.wdata[CC_CPU_DIV_LSB +: 2];
         fast_wake <= bus_i.wdata[CC_FAST_WAKE];
         auto_switch <= bus_i.wdata[CC_AUTO_SWITCH];
      end
   end

   // Fast RC only during wake; crystal takes over when ready or commanded
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fast_src <= 1'b0;
      end else if (sn.wake_from_sleep && fast_wake) begin
         fast_src <= 1'b1;
      end else if (fast_src && auto_switch && sn.xtal_ready) begin
         fast_src <= 1'b0;
      end else if (fast_src && wr_clk && bus_i.wdata[CC_SW_SWITCH]) begin
         fast_src <= 1'b0;
      end
   end

   // Only the first non-RC selection after a chip reset is kept
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slow_sel <= CRS_SLOW_RC;
         slow_locked <= 1'b0;
      end else if (state inside {CRS_ST_OFF, CRS_ST_SW_PULSE, CRS_ST_PIN_HOLD}) begin
         slow_sel <= CRS_SLOW_RC;
         slow_locked <= 1'b0;
      end else if (wr_clk && !slow_locked
                   && bus_i.wdata[CC_SLOW_SEL_LSB +: 2] != 2'(CRS_SLOW_RC)
                   && bus_i.wdata[CC_SLOW_SEL_LSB +: 2] <= 2'(CRS_SLOW_EXT)) begin
         slow_sel <= bus_i.wdata[CC_SLOW_SEL_LSB +: 2];
         slow_locked <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_div_o <= CRS_CPU_16M;
         fast_src_o <= 1'b0;
         radio_en_o <= 1'b0;
         slow_sel_o <= CRS_SLOW_RC;
         xtal_en_o <= 1'b0;
      end else begin
         cpu_div_o <= cpu_div;
         fast_src_o <= fast_src;
         radio_en_o <= !fast_src && core_reset_n_o;
         slow_sel_o <= slow_sel;
         xtal_en_o <= state != CRS_ST_OFF && state != CRS_ST_SLOW_SETTLE;
      end
   end

   // Calibration written as two bytes, low byte held until high arrives
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slow_cal_o <= CAL_RESET;
         cal_lo_hold <= '0;
      end else if (wr_cal) begin
         cal_lo_hold <= {8'h00, bus_i.wdata};
      end else if (bus_i.wr && bus_i.addr == ADDR_CAL_HI) begin
         slow_cal_o <= {bus_i.wdata, cal_lo_hold[7:0]};
      end
   end

   // ----------------------------------------------------------------
   // Software reset, line pull, brown-out
   // ----------------------------------------------------------------
   logic bod_irq_en, bod_prev, bod_latched, bod_lvl_loaded;
   logic [1:0] bod_lvl;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_rst_req <= 1'b0;
         soft_pull <= 1'b1;
         ext_hold <= 1'b0;
      end else begin
         sw_rst_req <= wr_rst && bus_i.wdata[RC_SW_RESET] && state == CRS_ST_RUN;
         if (wr_rst) begin
            soft_pull <= bus_i.wdata[RC_PIN_ON_SW];
            ext_hold <= bus_i.wdata[RC_EXT_HOLD];
         end else if (state == CRS_ST_OFF) begin
            ext_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bod_rst_en <= 1'b1;
         bod_irq_en <= 1'b0;
         bod_lvl <= CRS_BOD_2V3;
         bod_lvl_loaded <= 1'b0;
      end else if (!bod_lvl_loaded) begin
         bod_lvl <= fuse_bod_lvl_i;
         bod_lvl_loaded <= 1'b1;
      end else if (wr_bod) begin
         bod_lvl <= bus_i.wdata[BC_LEVEL_LSB +: 2];
         bod_rst_en <= bus_i.wdata[BC_RST_EN];
         bod_irq_en <= bus_i.wdata[BC_IRQ_EN];
      end
   end

   // Crossing flag: set wins over clear
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bod_prev <= 1'b1;
         bod_latched <= 1'b0;
      end else begin
         bod_prev <= sn.bod_above;
         if (bod_irq_en && bod_prev != sn.bod_above) begin
            bod_latched <= 1'b1;
         end else if (bus_i.wr && bus_i.addr == ADDR_STATUS
                      && bus_i.wdata[ST_BOD_IRQ]) begin
            bod_latched <= 1'b0;
         end
      end
   end

   // Watchdog cause survives the reset it causes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdog_flag <= 1'b0;
      end else if (sn.wdog_expired) begin
         wdog_flag <= 1'b1;
      end else if (!sn.por_ok) begin
         wdog_flag <= 1'b0;
      end else if (bus_i.wr && bus_i.addr == ADDR_STATUS && bus_i.wdata[ST_WDOG]) begin
         wdog_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bod_lvl_o <= CRS_BOD_2V3;
         bod_irq_o <= 1'b0;
      end else begin
         bod_lvl_o <= bod_lvl;
         bod_irq_o <= bod_latched;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (bus_i.addr == ADDR_CLK_CTRL) begin
         next_rdata = {1'b0, 1'b0, auto_switch, fast_wake, slow_sel, cpu_div};
      end else if (bus_i.addr == ADDR_RST_CTRL) begin
         next_rdata = {5'h00, ext_hold, soft_pull, 1'b0};
      end else if (bus_i.addr == ADDR_BOD_CTRL) begin
         next_rdata = {4'h0, bod_irq_en, bod_rst_en, bod_lvl};
      end else if (bus_i.addr == ADDR_CAL) begin
         next_rdata = slow_cal_o[7:0];
      end else if (bus_i.addr == ADDR_CAL_HI) begin
         next_rdata = slow_cal_o[15:8];
      end else if (bus_i.addr == ADDR_STATUS) begin
         next_rdata = {3'h0, bod_latched, !sn.bod_above, !fast_src, fast_src, wdog_flag};
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : crs_sequencer

// file: crs_checker.sv
// Assertions on the ports of the clock and reset sequencer, bound to it.
// Assumes the fixed settle counts declared in the package.
`timescale 1ns/1ps
module crs_checker (
   input wire logic ref_clk_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire crs_pkg::crs_bus_t bus_i, // Register request
   input wire logic [7:0] rdata_o, // Read data
   input wire crs_pkg::crs_sense_t sense_i, // Levels
   input wire logic chip_reset_pin_n_o, // Pin drive value
   input wire logic core_reset_n_o, // Core reset
   input wire logic xtal_en_o, // Crystal enable
   input wire logic fast_src_o, // Fast source
   input wire logic radio_en_o, // Radio usable
   input wire logic [1:0] slow_sel_o, // Slow source
   input wire logic [crs_pkg::CAL_W-1:0] slow_cal_o // Calibration
);
   import crs_pkg::*;
   int unsigned n_slow;
   int unsigned n_xtal;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ------------------------------------------------------------
   // Settle counters, too long for repetitions
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) n_slow <= 0;
      else if (xtal_en_o || !sense_i.por_ok) n_slow <= 0;
      else n_slow <= n_slow + 1;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) n_xtal <= 0;
      else if (core_reset_n_o || !xtal_en_o) n_xtal <= 0;
      else n_xtal <= n_xtal + 1;
   end
   property p_rd_idle;
      !bus_i.rd |=> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_no_drive_high;
      chip_reset_pin_n_o == 1'b0;
   endproperty
   a_no_drive_high: assert property (p_no_drive_high) else $error("pin drive value high");
   property p_slow_settle;
      $rose(xtal_en_o) |-> n_slow >= SLOW_RC_SETTLE_CYC;
   endproperty
   a_slow_settle: assert property (p_slow_settle) else $error("crystal enabled early");
   property p_xtal_settle;
      $rose(core_reset_n_o) |-> n_xtal >= XTAL_SETTLE_CYC;
   endproperty
   a_xtal_settle: assert property (p_xtal_settle) else $error("core released early");
   property p_release_cond;
      $rose(core_reset_n_o) |-> xtal_en_o && sense_i.bod_above;
   endproperty
   a_release_cond: assert property (p_release_cond) else $error("release without supply");
   property p_radio_fast;
      fast_src_o |-> !radio_en_o;
   endproperty
   a_radio_fast: assert property (p_radio_fast) else $error("radio on fast source");
   property p_slow_lock;
      slow_sel_o != 2'h0 |=> $stable(slow_sel_o) || slow_sel_o == 2'h0;
   endproperty
   a_slow_lock: assert property (p_slow_lock) else $error("slow source changed");
   property p_cal_pair;
      $changed(slow_cal_o) |-> (($past(bus_i.wr) && $past(bus_i.addr) == ADDR_CAL_HI)
         || slow_cal_o == CAL_RESET);
   endproperty
   a_cal_pair: assert property (p_cal_pair) else $error("calibration changed alone");
endmodule : crs_checker

bind crs_sequencer crs_checker u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .sense_i(sense_i), .chip_reset_pin_n_o(chip_reset_pin_n_o),
   .core_reset_n_o(core_reset_n_o), .xtal_en_o(xtal_en_o), .fast_src_o(fast_src_o),
   .radio_en_o(radio_en_o), .slow_sel_o(slow_sel_o), .slow_cal_o(slow_cal_o));

// file: crs_reset_line.sv
// Reset line as seen from outside: pull-up and board capacitance.
// Assumes the device only ever pulls low.
`timescale 1ns/1ps
module crs_reset_line (
   input wire logic clk_i, // Clock
   input wire logic oe_i, // Device pull-low enable
   input wire logic [15:0] rise_cyc_i, // Charge time in cycles
   output logic line_n_o // Resolved line level
);
   logic [15:0] charge = 16'h0000;
   // Slow RC charge, so a release is not seen at once
   always_ff @(posedge clk_i) begin
      if (oe_i) charge <= 16'h0000;
      else if (charge < rise_cyc_i) charge <= charge + 16'h0001;
   end
   assign line_n_o = !oe_i && (charge >= rise_cyc_i);
endmodule : crs_reset_line

// file: tb.sv
// Self-checking bench for the clock and reset sequencer.
// Assumes package counts; one power-up fits the run length.
`timescale 1ns/1ps
module tb;
   import crs_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   crs_bus_t bus = '0;
   crs_sense_t sense = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [15:0] rise_cyc = 16'h0005;
   logic [1:0] fuse = 2'h3;
   logic [7:0] rdata, v;
   logic pin_in, pin_o, oe, core_n, xtal, fast, radio, irq;
   logic [1:0] div, ssel, blvl;
   logic [15:0] cal;
   int n_mismatch = 0;
   int n_tests = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   crs_sequencer DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
      .sense_i(sense), .fuse_bod_lvl_i(fuse), .chip_reset_pin_n_i(pin_in),
      .chip_reset_pin_n_o(pin_o), .chip_reset_pin_n_oe_o(oe), .core_reset_n_o(core_n),
      .xtal_en_o(xtal), .fast_src_o(fast), .cpu_div_o(div), .radio_en_o(radio),
      .slow_sel_o(ssel), .bod_lvl_o(blvl), .slow_cal_o(cal), .bod_irq_o(irq));
   crs_reset_line u_line (.clk_i(ref_clk_i), .oe_i(oe), .rise_cyc_i(rise_cyc), .line_n_o(pin_in));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic finish_test;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         n_mismatch++;
      end
   endtask : chk
   task automatic bound(input int i, input int lim);
      if (i >= lim) begin
         $display("unexpected at %0t: wait bound %h used up", $time, lim);
         n_mismatch++;
         finish_test();
      end
   endtask : bound
   // Sample one step after the edge, once its updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk_i);
      bus.wr <= 1'b0;
      cyc(2);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk_i);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_powerup;
      int i;
      cyc(3);
      chk(ssel, 16'h0000);
      chk(blvl, 16'h0003);
      chk(cal, 16'h8000);
      sense.por_ok <= 1'b1;
      cyc(9000);
      chk(xtal, 16'h0000);
      for (i = 0; i < 2000 && xtal !== 1'b1; i++) cyc(1);
      bound(i, 2000);
      sense.bod_above <= 1'b0;
      cyc(74900);
      chk(core_n, 16'h0000);
      cyc(200);
      chk(core_n, 16'h0000);
      sense.bod_above <= 1'b1;
      for (i = 0; i < 20 && core_n !== 1'b1; i++) cyc(1);
      bound(i, 20);
      chk(oe, 16'h0000);
      chk(pin_in, 16'h0001);
      $display("power-up test done");
   endtask : t_powerup
   task automatic t_regs;
      for (int j = 0; j < 4; j++) begin
         wr(ADDR_CLK_CTRL, 8'h04 | 8'(j));
         chk(div, 16'(j));
         wr(ADDR_BOD_CTRL, 8'h04 | 8'(j));
         chk(blvl, 16'(j));
      end
      chk(ssel, 16'h0001);
      wr(ADDR_CLK_CTRL, 8'h0A);
      chk(ssel, 16'h0001);
      wr(ADDR_CAL, 8'h34);
      chk(cal, 16'h8000);
      wr(ADDR_CAL_HI, 8'h12);
      chk(cal, 16'h1234);
      rd(4'h7, v);
      chk(v, 16'h0000);
      rd(ADDR_STATUS, v);
      chk(v & 8'h06, 16'h0004);
      chk(radio, 16'h0001);
      chk(fast, 16'h0000);
      wr(ADDR_CLK_CTRL, 8'h12);
      sense.wake_from_sleep <= 1'b1;
      cyc(5);
      chk(fast, 16'h0001);
      chk(radio, 16'h0000);
      sense.wake_from_sleep <= 1'b0;
      cyc(3);
      chk(fast, 16'h0001);
      wr(ADDR_CLK_CTRL, 8'h52);
      chk(fast, 16'h0000);
      chk(radio, 16'h0001);
      $display("register test done");
   endtask : t_regs
   task automatic t_hold;
      int i;
      wr(ADDR_RST_CTRL, 8'h06);
      chk(oe, 16'h0001);
      chk(pin_in, 16'h0000);
      rise_cyc <= 16'd2000;
      cyc(50);
      chk(core_n, 16'h0001);
      wr(ADDR_RST_CTRL, 8'h02);
      chk(oe, 16'h0000);
      for (i = 0; i < 3000 && pin_in !== 1'b1; i++) cyc(1);
      bound(i, 3000);
      cyc(20);
      chk(core_n, 16'h0001);
      $display("line hold test done");
   endtask : t_hold
   task automatic t_sw;
      int i;
      int n;
      rise_cyc <= 16'h0005;
      wr(ADDR_RST_CTRL, 8'h03);
      for (i = 0; i < 10 && oe !== 1'b1; i++) cyc(1);
      bound(i, 10);
      chk(core_n, 16'h0000);
      for (n = 0; n < 300 && oe === 1'b1; n++) cyc(1);
      chk(16'(n), 16'(SW_PULSE_CYC));
      chk(ssel, 16'h0000);
      chk(core_n, 16'h0000);
      $display("software reset test done");
   endtask : t_sw
   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_powerup();
      t_regs();
      t_hold();
      t_sw();
      finish_test();
   end
endmodule : tb
